// File: rtl/xic_ctrl.sv
// External pin interrupt block with its AHB-Lite register file.
//
// Overview of operation
// - Each pin selects rise, fall, both, high, low.
// - Pin flag sets when its condition holds.
// - Edge mode re-sets only on a new edge.
// - Level mode re-sets at once while level holds.
// - Filter takes majority of three samples.
// - Unfiltered level detection needs no generic clock.
// - Filtering or edge sense requests the generic clock, on maskable pins only while enabled.
// - Latency bounded by three bus plus generic periods.
// - Enable bit turns maskable detection on and off.
// - Soft reset restores all registers, block disabled.
// - Non-maskable pin has its own sense and filter.
// - Non-maskable detection ignores the enable bit.
// - Non-maskable flag always drives its request.
// - Enable set and clear registers per pin.
// - Request while flag set and interrupt enabled.
// - One shared request, one non-maskable request.
// - Event output per pin when enabled.
// - Wake request from pins with wake enable.
// - Busy flag during sync; stall a second sync.
// - Soft reset and enable writes are synchronized.
// - Writing zero to soft reset does nothing.
// - Enable bit reads back the written value at once.
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module xic_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] pin_irq_input,
   input wire logic nmi_pin,
   input wire logic gclk_enabled,
   output logic filter_gen_clock_req,
   output logic irq_ext,
   output logic irq_nmi,
   output logic [15:0] event_out,
   output logic wake_req
);
   localparam int NALL = xic_pkg::NPINS + 1;

   logic [NALL-1:0] pin_meta;
   logic [NALL-1:0] pin_sync;
   logic [NALL-1:0] hit;
   logic [NALL*xic_pkg::CFG_WIDTH-1:0] all_cfg;
   logic [NALL-1:0] needs_gclk;

   logic [7:0] div_cnt;
   logic gclk_tick;

   logic dp_write;
   logic [7:0] dp_idx;
   logic addr_ok;
   logic wr_done;
   logic [7:0] addr_idx;
   logic [31:0] read_word;
   logic sync_start;

   logic [3:0] sync_cnt;
   logic sync_busy;
   logic soft_reset_bit_pend;
   logic enable_eff;
   logic soft_clr;

   logic ctrl_enable;
   logic [3:0] nonmask_control_reg;
   logic nmi_flag;
   logic [15:0] event_output_control_reg;
   logic [15:0] inten;
   logic [15:0] flags;
   logic [15:0] wake_en;
   logic [63:0] config_bits;
   logic [15:0] next_flags;
   logic [15:0] flag_clr;

   // Only whole-word transfers exist on this bus, so hsize is not decoded.
   assign addr_idx = haddr[9:2];
   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_done = dp_write && hreadyout;
   assign sync_start = wr_done && dp_idx == xic_pkg::IDX_CTRL;
   assign sync_busy = sync_cnt != 4'h0;
   assign all_cfg = {nonmask_control_reg, config_bits};

   // Both flops reset low, so a pin that is high at release reads as a new level two edges later.
   // two-flop synchronizer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {nmi_pin, pin_irq_input};
         pin_sync <= pin_meta;
      end
   end

   // The generic clock is a divided enable; it runs only while requested and granted.
   // Holding the divider still while nothing needs it saves power and freezes the filters.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 8'h00;
         gclk_tick <= 1'b0;
      end else if (!filter_gen_clock_req || !gclk_enabled) begin
         div_cnt <= 8'h00;
         gclk_tick <= 1'b0;
      end else if (div_cnt == xic_pkg::GCLK_DIV - 8'h01) begin
         div_cnt <= 8'h00;
         gclk_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h01;
         gclk_tick <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NALL; gi++) begin : g_pin
         xic_pkg::xic_pin_cfg_t cfg;
         assign cfg = all_cfg[gi*xic_pkg::CFG_WIDTH +: xic_pkg::CFG_WIDTH];
         assign needs_gclk[gi] = cfg.filt || cfg.sense == xic_pkg::SENSE_RISE
            || cfg.sense == xic_pkg::SENSE_FALL || cfg.sense == xic_pkg::SENSE_BOTH;
         xic_pin_detect u_det (
            .hclk(hclk),
            .hresetn(hresetn),
            .clear(soft_clr),
            .tick(gclk_tick),
            .pin(pin_sync[gi]),
            .cfg(cfg),
            .hit(hit[gi])
         );
      end
   endgenerate

   // Data phase capture.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_idx <= 8'h00;
      end else if (hready) begin
         dp_write <= addr_ok && hwrite;
         dp_idx <= addr_idx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else if (!hreadyout) begin
         hreadyout <= !sync_busy;
      // A control write still landing counts as busy, so a pipelined second write waits too.
      end else if (addr_ok && hwrite && addr_idx == xic_pkg::IDX_CTRL && (sync_busy || sync_start)) begin
         hreadyout <= 1'b0;
      end
   end

   // Every transfer is answered OKAY; a stall takes the place of any error.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   always_comb begin
      read_word = xic_pkg::RST_WORD;
      unique case (addr_idx)
         xic_pkg::IDX_CTRL: begin
            read_word[xic_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
            read_word[xic_pkg::CTRL_SOFT_RESET_BIT_BIT] = soft_reset_bit_pend;
         end
         xic_pkg::IDX_STATUS: read_word[xic_pkg::STATUS_BUSY_BIT] = sync_busy;
         xic_pkg::IDX_NONMASK_CONTROL_REG: read_word[3:0] = nonmask_control_reg;
         xic_pkg::IDX_NONMASK_FLAG_REG: read_word[0] = nmi_flag;
         xic_pkg::IDX_EVENT_OUTPUT_CONTROL_REG: read_word[15:0] = event_output_control_reg;
         xic_pkg::IDX_IRQ_ENABLE_CLEAR_REG, xic_pkg::IDX_IRQ_ENABLE_SET_REG: read_word[15:0] = inten;
         xic_pkg::IDX_PIN_FLAG_REG: read_word[15:0] = flags;
         xic_pkg::IDX_WAKEUP: read_word[15:0] = wake_en;
         xic_pkg::IDX_CONFIG0: read_word = config_bits[31:0];
         xic_pkg::IDX_CONFIG1: read_word = config_bits[63:32];
         default: read_word = xic_pkg::RST_WORD;
      endcase
   end

   // Read data is taken in the address phase so hrdata comes from a flop.
   // A read whose address phase meets a write's data phase still sees the old value.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= xic_pkg::RST_WORD;
      end else if (addr_ok && !hwrite) begin
         hrdata <= read_word;
      end
   end

   // zero to soft reset is ignored.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_cnt <= 4'h0;
         soft_reset_bit_pend <= 1'b0;
         enable_eff <= 1'b0;
         soft_clr <= 1'b0;
      end else begin
         soft_clr <= 1'b0;
         if (sync_start) begin
            // Enable and soft reset wait out the same delay, so they land together.
            sync_cnt <= xic_pkg::SYNC_CYCLES;
            soft_reset_bit_pend <= hwdata[xic_pkg::CTRL_SOFT_RESET_BIT_BIT];
         end else if (sync_cnt == 4'h1) begin
            sync_cnt <= 4'h0;
            enable_eff <= soft_reset_bit_pend ? 1'b0 : ctrl_enable;
            soft_clr <= soft_reset_bit_pend;
            soft_reset_bit_pend <= 1'b0;
         end else if (sync_busy) begin
            sync_cnt <= sync_cnt - 4'h1;
         end
      end
   end

   // Configuration registers; all return to reset on a soft reset.
   // These take effect at once, so software finishes them before it sets enable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_enable <= 1'b0;
         nonmask_control_reg <= xic_pkg::RST_CFG;
         event_output_control_reg <= xic_pkg::RST_PINS;
         wake_en <= xic_pkg::RST_PINS;
         config_bits <= {xic_pkg::RST_WORD, xic_pkg::RST_WORD};
      end else if (soft_clr) begin
         ctrl_enable <= 1'b0;
         nonmask_control_reg <= xic_pkg::RST_CFG;
         event_output_control_reg <= xic_pkg::RST_PINS;
         wake_en <= xic_pkg::RST_PINS;
         config_bits <= {xic_pkg::RST_WORD, xic_pkg::RST_WORD};
      end else if (wr_done) begin
         unique case (dp_idx)
            xic_pkg::IDX_CTRL: ctrl_enable <= hwdata[xic_pkg::CTRL_ENABLE_BIT];
            xic_pkg::IDX_NONMASK_CONTROL_REG: nonmask_control_reg <= hwdata[3:0];
            xic_pkg::IDX_EVENT_OUTPUT_CONTROL_REG: event_output_control_reg <= hwdata[15:0];
            xic_pkg::IDX_WAKEUP: wake_en <= hwdata[15:0];
            xic_pkg::IDX_CONFIG0: config_bits[31:0] <= hwdata;
            xic_pkg::IDX_CONFIG1: config_bits[63:32] <= hwdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inten <= xic_pkg::RST_PINS;
      end else if (soft_clr) begin
         inten <= xic_pkg::RST_PINS;
      end else if (wr_done && dp_idx == xic_pkg::IDX_IRQ_ENABLE_SET_REG) begin
         inten <= inten | hwdata[15:0];
      end else if (wr_done && dp_idx == xic_pkg::IDX_IRQ_ENABLE_CLEAR_REG) begin
         inten <= inten & ~hwdata[15:0];
      end
   end

   assign flag_clr = (wr_done && dp_idx == xic_pkg::IDX_PIN_FLAG_REG) ? hwdata[15:0] : xic_pkg::RST_PINS;
   // set on condition; a set in the clearing cycle wins.
   // a held level sets again at once.
   assign next_flags = (flags & ~flag_clr) | (hit[15:0] & {16{enable_eff}});

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= xic_pkg::RST_PINS;
      end else if (soft_clr) begin
         flags <= xic_pkg::RST_PINS;
      end else begin
         flags <= next_flags;
      end
   end

   // A detection in the clearing cycle keeps the flag, so no request is lost.
   // non-maskable detection ignores enable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_flag <= 1'b0;
      end else if (soft_clr) begin
         nmi_flag <= 1'b0;
      end else if (hit[xic_pkg::NPINS]) begin
         nmi_flag <= 1'b1;
      end else if (wr_done && dp_idx == xic_pkg::IDX_NONMASK_FLAG_REG && hwdata[0]) begin
         nmi_flag <= 1'b0;
      end
   end

   // Request outputs are registered, which adds one cycle after the flag.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ext <= 1'b0;
         irq_nmi <= 1'b0;
      end else begin
         irq_ext <= |(flags & inten);
         irq_nmi <= nmi_flag;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_out <= xic_pkg::RST_PINS;
         wake_req <= 1'b0;
      end else begin
         // Level-sensed pins hold their event; edge-sensed pins pulse for one cycle.
         // gated events.
         event_out <= hit[15:0] & event_output_control_reg & {16{enable_eff}};
         wake_req <= enable_eff && |(hit[15:0] & wake_en);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filter_gen_clock_req <= 1'b0;
      end else begin
         filter_gen_clock_req <= (enable_eff && |needs_gclk[15:0]) || needs_gclk[xic_pkg::NPINS];
      end
   end
endmodule

// File: include/xic_pkg.sv
// Constants and types shared by the external pin interrupt block.
package xic_pkg;
   localparam int NPINS = 16;
   // Sense field encodings.
   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_RISE = 3'h1;
   localparam logic [2:0] SENSE_FALL = 3'h2;
   localparam logic [2:0] SENSE_BOTH = 3'h3;
   localparam logic [2:0] SENSE_HIGH = 3'h4;
   localparam logic [2:0] SENSE_LOW = 3'h5;
   // Register indexes; the byte address is four times the index.
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_STATUS = 8'h01;
   localparam logic [7:0] IDX_NONMASK_CONTROL_REG = 8'h02;
   localparam logic [7:0] IDX_NONMASK_FLAG_REG = 8'h03;
   localparam logic [7:0] IDX_EVENT_OUTPUT_CONTROL_REG = 8'h04;
   localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR_REG = 8'h08;
   localparam logic [7:0] IDX_IRQ_ENABLE_SET_REG = 8'h0c;
   localparam logic [7:0] IDX_PIN_FLAG_REG = 8'h10;
   localparam logic [7:0] IDX_WAKEUP = 8'h14;
   localparam logic [7:0] IDX_CONFIG0 = 8'h18;
   localparam logic [7:0] IDX_CONFIG1 = 8'h1c;
   // Field positions.
   localparam int CTRL_SOFT_RESET_BIT_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int STATUS_BUSY_BIT = 7;
   localparam int CFG_WIDTH = 4;
   // Reset values.
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_PINS = 16'h0000;
   localparam logic [3:0] RST_CFG = 4'h0;
   // Cycle counts at the 40 MHz bus clock.
   localparam logic [7:0] GCLK_DIV = 8'h04;
   localparam logic [3:0] SYNC_CYCLES = 4'h4;

   typedef struct packed {
      logic filt;
      logic [2:0] sense;
   } xic_pin_cfg_t;
endpackage

// File: rtl/xic_pin_detect.sv
// Per-pin filter and edge or level detector.
`timescale 1ns/100ps
module xic_pin_detect (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic tick,
   input wire logic pin,
   input xic_pkg::xic_pin_cfg_t cfg,
   output logic hit
);
   logic [2:0] samples;
   logic prev;
   logic edge_hit;
   logic maj;
   logic value;

   assign maj = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
   assign value = cfg.filt ? maj : pin;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samples <= 3'h0;
      end else if (clear) begin
         samples <= 3'h0;
      end else if (tick) begin
         samples <= {samples[1:0], pin};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev <= 1'b0;
         edge_hit <= 1'b0;
      end else if (clear) begin
         prev <= 1'b0;
         edge_hit <= 1'b0;
      end else if (tick) begin
         prev <= value;
         edge_hit <= ((cfg.sense == xic_pkg::SENSE_RISE || cfg.sense == xic_pkg::SENSE_BOTH) && value && !prev)
            || ((cfg.sense == xic_pkg::SENSE_FALL || cfg.sense == xic_pkg::SENSE_BOTH) && !value && prev);
      end else begin
         edge_hit <= 1'b0;
      end
   end

   // level path needs no tick when unfiltered.
   always_comb begin
      unique case (cfg.sense)
         xic_pkg::SENSE_HIGH: hit = value;
         xic_pkg::SENSE_LOW: hit = !value;
         xic_pkg::SENSE_RISE, xic_pkg::SENSE_FALL, xic_pkg::SENSE_BOTH: hit = edge_hit;
         default: hit = 1'b0;
      endcase
   end
endmodule

// File: sim/xic_pin_model.sv
// Outside circuitry that drives the external interrupt pins.
`timescale 1ns/100ps
module xic_pin_model (
   input wire logic [15:0] want,
   input wire logic want_nmi,
   input wire logic spike,
   output logic [15:0] pins,
   output logic nmi
);
   // The spike flips pin 2 while held; four cycles reach one filter sample only, too few to win a vote.
   assign pins = want ^ {13'h0, spike, 2'h0};
   assign nmi = want_nmi;
endmodule

// File: sim/xic_ctrl_chk.sv
// Port-level assertions for the external pin interrupt block.
`timescale 1ns/100ps
module xic_ctrl_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq_ext,
   input wire logic irq_nmi,
   input wire logic [15:0] event_out,
   input wire logic wake_req
);
   logic wr_req;
   logic rd_req;
   logic ctrl_req;
   logic [4:0] wr_age;
   assign wr_req = hsel && htrans[1] && hready && hwrite;
   assign rd_req = hsel && htrans[1] && hready && !hwrite;
   assign ctrl_req = hsel && htrans[1] && hwrite && haddr[9:2] == xic_pkg::IDX_CTRL;
   // Requests only drop by software action, so they must fall soon after some write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_age <= 5'h1f;
      end else if (wr_req) begin
         wr_age <= 5'h00;
      end else if (wr_age != 5'h1f) begin
         wr_age <= wr_age + 5'h01;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence ctrl_wr;
      ctrl_req && hready;
   endsequence
   sequence sw_reset;
      ctrl_wr ##1 hwdata[0];
   endsequence
   chk_nmi_held: assert property ($fell(irq_nmi) |-> wr_age < 5'h14)
      else $error("irq_nmi fell with no write");
   chk_ext_held: assert property ($fell(irq_ext) |-> wr_age < 5'h14)
      else $error("irq_ext fell with no write");
   chk_soft_clear: assert property (sw_reset |-> ##[12:16] (!irq_ext && !irq_nmi && event_out == 16'h0 && !wake_req))
      else $error("soft reset left outputs active");
   chk_stall_bound: assert property ($fell(hreadyout) |-> ##[1:6] hreadyout)
      else $error("bus stall too long");
   chk_stall_cause: assert property ($fell(hreadyout) |-> $past(ctrl_req))
      else $error("stall without a control write");
   chk_read_ready: assert property (rd_req |=> hreadyout)
      else $error("read was stalled");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   chk_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
      else $error("read data changed without a read");
endmodule
bind xic_ctrl xic_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hrdata, .hreadyout, .hresp, .irq_ext, .irq_nmi, .event_out, .wake_req);

// File: sim/xic_ctrl_tb.sv
// Self-checking bench for the external pin interrupt block.
`timescale 1ns/100ps
module xic_ctrl_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] want = 16'h0028;
   logic want_nmi = 1'b0;
   logic spike = 1'b0;
   logic gclk_enabled = 1'b0;
   logic [31:0] hrdata, rv;
   logic hreadyout, hresp, nmi, filter_gen_clock_req, irq_ext, irq_nmi, wake_req;
   logic [15:0] pins, event_out;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] regs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h3f};
   always #12.5 hclk = ~hclk;
   xic_pin_model PINS (.want, .want_nmi, .spike, .pins, .nmi);
   xic_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .pin_irq_input(pins), .nmi_pin(nmi), .gclk_enabled, .filter_gen_clock_req,
      .irq_ext, .irq_nmi, .event_out, .wake_req);
   task final_report;
      if (num_errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for the slave's ready; a stall past the limit ends the run.
   task hold;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 20) begin
            chk({31'h0, hreadyout}, 32'h1);
            final_report;
         end
         @(posedge hclk);
      end
   endtask
   task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      hold;
      rv = hrdata;
   endtask
   task wr(input logic [7:0] idx, input logic [31:0] wd);
      xfer(1'b1, idx, wd);
   endtask
   task rchk(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk(rv, exp);
   endtask
   task wait_irq(input logic e, input logic n, input int lim);
      int k;
      k = 0;
      while ((irq_ext !== e || irq_nmi !== n) && k < lim) begin
         @(posedge hclk);
         k++;
      end
      chk({30'h0, irq_ext, irq_nmi}, {30'h0, e, n});
      if (irq_ext !== e || irq_nmi !== n) final_report;
   endtask
   task all_zero;
      foreach (regs[i]) rchk(regs[i], 32'h0);
   endtask
   task idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   initial begin
      idle(16);
      hresetn <= 1'b1;
      idle(1);
      all_zero();
      gclk_enabled <= 1'b1;
      wr(xic_pkg::IDX_CONFIG0, 32'h0053_2c14);
      wr(xic_pkg::IDX_EVENT_OUTPUT_CONTROL_REG, 32'h1);
      wr(xic_pkg::IDX_WAKEUP, 32'h1);
      wr(xic_pkg::IDX_IRQ_ENABLE_SET_REG, 32'h1);
      wr(xic_pkg::IDX_CTRL, 32'h2);
      rchk(xic_pkg::IDX_STATUS, 32'h80);
      rchk(xic_pkg::IDX_CTRL, 32'h2);
      rchk(xic_pkg::IDX_CONFIG0, 32'h0053_2c14);
      idle(8);
      chk({31'h0, filter_gen_clock_req}, 32'h1);
      spike <= 1'b1;
      idle(4);
      spike <= 1'b0;
      idle(30);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h0);
      want <= 16'h0029;
      wait_irq(1'b1, 1'b0, 5);
      chk({event_out, 15'h0, wake_req}, 32'h0001_0001);
      wr(xic_pkg::IDX_PIN_FLAG_REG, 32'h1);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h1);
      wr(xic_pkg::IDX_IRQ_ENABLE_CLEAR_REG, 32'h1);
      wait_irq(1'b0, 1'b0, 8);
      rchk(xic_pkg::IDX_IRQ_ENABLE_SET_REG, 32'h0);
      wr(xic_pkg::IDX_IRQ_ENABLE_SET_REG, 32'h1);
      wait_irq(1'b1, 1'b0, 8);
      want <= 16'h0028;
      wr(xic_pkg::IDX_EVENT_OUTPUT_CONTROL_REG, 32'h0);
      wr(xic_pkg::IDX_PIN_FLAG_REG, 32'h1);
      wait_irq(1'b0, 1'b0, 8);
      want <= 16'h0029;
      idle(6);
      chk({16'h0, event_out}, 32'h0);
      want <= 16'h0036;
      idle(1);
      wr(xic_pkg::IDX_PIN_FLAG_REG, 32'hffff);
      idle(30);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h1e);
      wr(xic_pkg::IDX_PIN_FLAG_REG, 32'hffff);
      idle(30);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h04);
      want <= 16'h000c;
      idle(30);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h34);
      wr(xic_pkg::IDX_CTRL, 32'h0);
      gclk_enabled <= 1'b0;
      wr(xic_pkg::IDX_NONMASK_CONTROL_REG, 32'h1);
      gclk_enabled <= 1'b1;
      idle(4);
      wr(xic_pkg::IDX_PIN_FLAG_REG, 32'hffff);
      want <= 16'h0001;
      idle(30);
      rchk(xic_pkg::IDX_PIN_FLAG_REG, 32'h0);
      want_nmi <= 1'b1;
      wait_irq(1'b0, 1'b1, 30);
      rchk(xic_pkg::IDX_NONMASK_FLAG_REG, 32'h1);
      want_nmi <= 1'b0;
      wr(xic_pkg::IDX_NONMASK_FLAG_REG, 32'h1);
      wait_irq(1'b0, 1'b0, 8);
      wr(xic_pkg::IDX_NONMASK_CONTROL_REG, 32'hc);
      want_nmi <= 1'b1;
      wait_irq(1'b0, 1'b1, 30);
      wr(xic_pkg::IDX_CTRL, 32'h2);
      rchk(xic_pkg::IDX_NONMASK_CONTROL_REG, 32'hc);
      wr(xic_pkg::IDX_CTRL, 32'h2);
      wr(xic_pkg::IDX_CTRL, 32'h1);
      idle(12);
      wait_irq(1'b0, 1'b0, 4);
      all_zero();
      gclk_enabled <= 1'b0;
      wr(xic_pkg::IDX_CONFIG0, 32'h4);
      wr(xic_pkg::IDX_IRQ_ENABLE_SET_REG, 32'h1);
      wr(xic_pkg::IDX_CTRL, 32'h2);
      idle(8);
      chk({31'h0, filter_gen_clock_req}, 32'h0);
      wait_irq(1'b1, 1'b0, 8);
      final_report;
   end
endmodule
